/* common/csr_priv_pkg.sv */
// Shared constants and types for the register-access privilege checker
package csr_priv_pkg;
    // Privilege level codes
    typedef logic [1:0] level_t;
    localparam level_t LVL_APP = 2'h0;
    localparam level_t LVL_OS = 2'h1;
    localparam level_t LVL_VMM = 2'h2;
    localparam level_t LVL_TOP = 2'h3;
    localparam level_t PRIV_RST = LVL_TOP;

    // Supported level sets, in growing order
    typedef enum logic [1:0] {
        SET_TOP = 2'h0,
        SET_TOP_APP = 2'h1,
        SET_TOP_OS_APP = 2'h2,
        SET_ALL = 2'h3
    } mode_set_t;

    // Instruction fields
    localparam int CSR_ADDR_W = 12;
    localparam logic [6:0] OPC_PRIV = 7'h73;
    localparam logic [2:0] F3_NOTREG = 3'h0;
    localparam logic [2:0] F3_RESERVED = 3'h4;
    localparam logic [1:0] F3_SWAP = 2'h1;
    localparam logic [11:0] FUNC_ENV_CALL = 12'h000;
    localparam logic [11:0] FUNC_BREAK = 12'h001;

    // Address map conventions
    localparam logic [1:0] ACC_RO = 2'h3;
    localparam logic [1:0] ACC_SHADOW = 2'h2;
    localparam logic [1:0] ACC_RW_HI = 2'h1;
    localparam logic [1:0] ACC_RW_LO = 2'h0;
    localparam logic [1:0] SUB_NONSTD = 2'h3;
    localparam logic [11:0] DBG_LO = 12'h7a0;
    localparam logic [11:0] DBG_HI = 12'h7bf;
    localparam logic [11:0] DBG_ONLY_LO = 12'h7b0;

    // Register bus offsets and fields
    localparam int REG_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVENT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam int CTRL_SET_LSB = 0;
    localparam int CTRL_DBG_BIT = 2;
    localparam int CTRL_ICPT_LSB = 4;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'h03;
    localparam logic [7:0] CTRL_WMASK = 8'hf7;

    // Event bits
    localparam int EV_NONEXIST = 0;
    localparam int EV_PRIV = 1;
    localparam int EV_RO = 2;
    localparam int EV_DEBUG = 3;
    localparam int EV_ICPT = 4;
    localparam int EV_W = 5;
    localparam logic [4:0] EV_RST = 5'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/csr_addr_decode.sv */
// Combinational decode of a 12-bit register address into its access attributes
`timescale 1ns/1ps
module csr_addr_decode (
    input wire logic [11:0] addr, // Register address
    output logic read_only, // Whole register is read-only
    output logic [1:0] min_level, // Lowest level allowed access
    output logic standard, // Standard rather than custom range
    output logic shadow, // Read/write shadow of a lower-level register
    output logic debug_range, // Reserved debug window
    output logic debug_only // Debug-mode-only part of that window
);
    wire [1:0] acc = addr[11:10];
    wire [1:0] sub = addr[7:6];

    // Access class and lowest level come straight from the upper bits
    assign read_only = (acc == csr_priv_pkg::ACC_RO);
    assign min_level = addr[9:8];
    // Shadows sit in the third access class above the application level
    assign shadow = (acc == csr_priv_pkg::ACC_SHADOW) && (addr[9:8] != csr_priv_pkg::LVL_APP);
    // Custom space: application shadow class, or top sub-block outside the plain low class and the application-level ACC_RW_HI class
    assign standard = !(((acc == csr_priv_pkg::ACC_SHADOW) && (addr[9:8] == csr_priv_pkg::LVL_APP))
        || ((acc != csr_priv_pkg::ACC_RW_LO)
        && !((acc == csr_priv_pkg::ACC_RW_HI) && (addr[9:8] == csr_priv_pkg::LVL_APP))
        && (sub == csr_priv_pkg::SUB_NONSTD)));
    assign debug_range = (addr >= csr_priv_pkg::DBG_LO) && (addr <= csr_priv_pkg::DBG_HI);
    assign debug_only = (addr >= csr_priv_pkg::DBG_ONLY_LO) && (addr <= csr_priv_pkg::DBG_HI);
endmodule

/* logic/csr_privilege_checker.sv */
// Privilege level holder and register-access checker with an AXI4-Lite control slave
`timescale 1ns/1ps
module csr_privilege_checker #(
    parameter int XLEN = 32 // Width of register data checked for read-only bits
) (
    input wire logic CLOCK, // Core clock, 40 MHz
    input wire logic RST_N, // Synchronous reset, active low
    input wire logic REQ_VALID, // Pipeline offers an instruction for checking
    input wire logic [31:0] INSN, // Instruction word
    input wire logic CSR_EXISTS, // Register file provides the addressed register
    input wire logic [XLEN-1:0] WR_DATA, // Value the instruction would write
    input wire logic [XLEN-1:0] OLD_DATA, // Present register value
    input wire logic [XLEN-1:0] RO_MASK, // Bits of the register that are read-only
    input wire logic DEBUG_MODE, // Hart runs in debug mode
    input wire logic PRIV_WR_VALID, // Trap or return sets a new level
    input wire logic [1:0] PRIV_WR_LEVEL, // Level to enter
    output logic [1:0] PRIV_LEVEL, // Current level
    output logic CHK_VALID, // Check result valid, one cycle
    output logic CHK_ILLEGAL, // Illegal-instruction exception
    output logic CHK_INTERCEPT, // Access trapped to a higher level
    output logic CHK_WRITE_EN, // Register write may commit
    output logic [3:0] CHK_CAUSE, // {ro, priv, debug, nonexist}
    output logic CHK_STANDARD, // Address in a standard range
    output logic CHK_SHADOW, // Address is a shadow
    output logic [XLEN-1:0] CHK_WDATA, // Write value with read-only bits kept
    output logic IRQ, // Unmasked event pending
    input wire logic [7:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Byte strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [7:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY // Read data ready
);
    logic [1:0] priv;
    logic [7:0] ctrl;
    logic [4:0] events;
    logic [4:0] mask;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Address attributes from the upper instruction field
    logic dec_ro;
    logic [1:0] dec_min;
    logic dec_std;
    logic dec_shadow;
    logic dec_dbg;
    logic dec_dbg_only;
    csr_addr_decode u_decode (
        .addr(INSN[31:20]),
        .read_only(dec_ro),
        .min_level(dec_min),
        .standard(dec_std),
        .shadow(dec_shadow),
        .debug_range(dec_dbg),
        .debug_only(dec_dbg_only)
    );

    // Implemented levels follow the configured set; top is always there
    function automatic logic lvl_impl(input logic [1:0] set, input logic [1:0] lvl);
        logic ok;
        ok = 1'b0;
        unique case (lvl)
            csr_priv_pkg::LVL_TOP: ok = 1'b1;
            csr_priv_pkg::LVL_APP: ok = (set != csr_priv_pkg::SET_TOP);
            csr_priv_pkg::LVL_OS: ok = (set == csr_priv_pkg::SET_TOP_OS_APP) || (set == csr_priv_pkg::SET_ALL);
            csr_priv_pkg::LVL_VMM: ok = (set == csr_priv_pkg::SET_ALL);
        endcase
        return ok;
    endfunction

    // Instruction class inside the privileged major opcode
    wire [1:0] mode_set = ctrl[csr_priv_pkg::CTRL_SET_LSB +: 2];
    wire dbg_impl = ctrl[csr_priv_pkg::CTRL_DBG_BIT];
    wire [3:0] icpt_en = ctrl[csr_priv_pkg::CTRL_ICPT_LSB +: 4];
    wire is_sys = (INSN[6:0] == csr_priv_pkg::OPC_PRIV);
    wire is_other = is_sys && (INSN[14:12] == csr_priv_pkg::F3_NOTREG);
    wire is_rsvd = is_sys && (INSN[14:12] == csr_priv_pkg::F3_RESERVED);
    wire is_csr = is_sys && (INSN[13:12] != 2'h0) && !is_rsvd;
    // Set and clear forms with a zero source only read, so they may touch read-only registers
    wire csr_wr = is_csr && ((INSN[13:12] == csr_priv_pkg::F3_SWAP) || (INSN[19:15] != 5'h00));
    wire is_env = (INSN[31:20] == csr_priv_pkg::FUNC_ENV_CALL) || (INSN[31:20] == csr_priv_pkg::FUNC_BREAK);
    wire [1:0] other_lvl = is_env ? csr_priv_pkg::LVL_APP : INSN[29:28];
    wire [1:0] req_lvl = is_csr ? dec_min : other_lvl;
    wire dbg_active = DEBUG_MODE && dbg_impl;

    // Refusal causes, each judged on its own
    wire f_nonexist = is_rsvd
        || (is_csr && (!CSR_EXISTS || !lvl_impl(mode_set, dec_min) || (dec_dbg_only && !dbg_impl)))
        || (is_other && !lvl_impl(mode_set, other_lvl));
    wire f_debug = is_csr && dec_dbg && !dbg_active;
    // Debug mode ranks above the top level and passes every level check
    wire f_priv = (is_csr || is_other) && !dbg_active && (priv < req_lvl);
    wire f_ro = csr_wr && dec_ro;
    wire f_any = f_nonexist || f_debug || f_priv || f_ro;
    // Interception turns a permitted access into a trap to the level above
    wire icpt = (is_csr || is_other) && !f_any && !dbg_active && (priv != csr_priv_pkg::LVL_TOP)
        && icpt_en[priv];
    wire wr_ok = csr_wr && !f_any && !icpt;
    wire [XLEN-1:0] merged = (OLD_DATA & RO_MASK) | (WR_DATA & ~RO_MASK);

    // Check results are registered together so the trap and the write gate arrive in one cycle
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            CHK_VALID <= 1'b0;
            CHK_ILLEGAL <= 1'b0;
            CHK_INTERCEPT <= 1'b0;
            CHK_WRITE_EN <= 1'b0;
            CHK_CAUSE <= 4'h0;
            CHK_STANDARD <= 1'b0;
            CHK_SHADOW <= 1'b0;
            CHK_WDATA <= '0;
        end
        else
        begin
            CHK_VALID <= REQ_VALID;
            CHK_ILLEGAL <= REQ_VALID && f_any;
            CHK_INTERCEPT <= REQ_VALID && icpt;
            CHK_WRITE_EN <= REQ_VALID && wr_ok;
            CHK_CAUSE <= REQ_VALID ? {f_ro, f_priv, f_debug, f_nonexist} : 4'h0;
            CHK_STANDARD <= REQ_VALID && is_csr && dec_std;
            CHK_SHADOW <= REQ_VALID && is_csr && dec_shadow;
            if (REQ_VALID)
                CHK_WDATA <= merged;
        end
    end

    // Level updates from the pipeline; an unimplemented target is ignored
    wire aw_go = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_go = S_AXI_WVALID && S_AXI_WREADY;
    wire do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
    wire wr_ctrl = do_write && (aw_addr == csr_priv_pkg::OFS_CTRL);
    wire wr_event = do_write && (aw_addr == csr_priv_pkg::OFS_EVENT);
    wire wr_mask = do_write && (aw_addr == csr_priv_pkg::OFS_MASK);
    wire wr_known = wr_ctrl || wr_event || wr_mask || (aw_addr == csr_priv_pkg::OFS_STATUS);
    wire [7:0] ctrl_new = (w_data[7:0] & csr_priv_pkg::CTRL_WMASK);
    wire [7:0] next_ctrl = (wr_ctrl && w_strb[0]) ? ctrl_new : ctrl;
    wire [1:0] next_set = next_ctrl[csr_priv_pkg::CTRL_SET_LSB +: 2];
    wire [1:0] next_priv_raw = (PRIV_WR_VALID && lvl_impl(mode_set, PRIV_WR_LEVEL)) ? PRIV_WR_LEVEL : priv;
    // Shrinking the level set drops a now missing level back to the top
    wire [1:0] next_priv = lvl_impl(next_set, next_priv_raw) ? next_priv_raw : csr_priv_pkg::LVL_TOP;
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            priv <= csr_priv_pkg::PRIV_RST;
        else
            priv <= next_priv;
    end
    assign PRIV_LEVEL = priv;

    // Control and mask registers
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            ctrl <= csr_priv_pkg::CTRL_RST;
            mask <= csr_priv_pkg::EV_RST;
        end
        else
        begin
            ctrl <= next_ctrl;
            if (wr_mask && w_strb[0])
                mask <= w_data[csr_priv_pkg::EV_W-1:0];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    wire [4:0] ev_set = REQ_VALID ? {icpt, f_debug, f_ro, f_priv, f_nonexist} : 5'h00;
    wire [4:0] ev_clr = (wr_event && w_strb[0]) ? w_data[csr_priv_pkg::EV_W-1:0] : 5'h00;
    wire [4:0] next_events = (events & ~ev_clr) | ev_set;
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            events <= csr_priv_pkg::EV_RST;
            IRQ <= 1'b0;
        end
        else
        begin
            events <= next_events;
            IRQ <= |(next_events & mask);
        end
    end

    // Write channel: address and data taken in either order, then one response
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= csr_priv_pkg::RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (aw_go)
            begin
                S_AXI_AWREADY <= 1'b0;
                aw_addr <= S_AXI_AWADDR;
            end
            if (w_go)
            begin
                S_AXI_WREADY <= 1'b0;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_known ? csr_priv_pkg::RESP_OKAY : csr_priv_pkg::RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    wire [31:0] rd_status = {28'h0, 1'b0, dbg_active, priv};
    wire rd_known = (S_AXI_ARADDR == csr_priv_pkg::OFS_CTRL) || (S_AXI_ARADDR == csr_priv_pkg::OFS_STATUS)
        || (S_AXI_ARADDR == csr_priv_pkg::OFS_EVENT) || (S_AXI_ARADDR == csr_priv_pkg::OFS_MASK);
    wire [31:0] rd_mux = (S_AXI_ARADDR == csr_priv_pkg::OFS_CTRL) ? {24'h0, ctrl}
        : (S_AXI_ARADDR == csr_priv_pkg::OFS_STATUS) ? rd_status
        : (S_AXI_ARADDR == csr_priv_pkg::OFS_EVENT) ? {27'h0, events}
        : (S_AXI_ARADDR == csr_priv_pkg::OFS_MASK) ? {27'h0, mask} : 32'h0000_0000;
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= csr_priv_pkg::RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= rd_known ? csr_priv_pkg::RESP_OKAY : csr_priv_pkg::RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Checks on the access decisions
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    sequence s_low_priv_access;
        REQ_VALID && is_csr && CSR_EXISTS && !DEBUG_MODE && !dec_dbg && (priv < INSN[29:28]);
    endsequence
    sequence s_trap;
        CHK_VALID && CHK_ILLEGAL && !CHK_WRITE_EN;
    endsequence
    sequence s_top_rw_access;
        REQ_VALID && is_csr && CSR_EXISTS && !dec_dbg && (priv == csr_priv_pkg::LVL_TOP)
            && (INSN[31:30] != csr_priv_pkg::ACC_RO) && lvl_impl(mode_set, dec_min);
    endsequence

    a_low_priv_trap: assert property (s_low_priv_access |=> s_trap and CHK_CAUSE[2])
        else $error("low privilege access not trapped");
    a_ro_write_trap: assert property (REQ_VALID && csr_wr && (INSN[31:30] == 2'h3) |=> s_trap)
        else $error("write to read-only register not trapped");
    a_refused_no_write: assert property (CHK_ILLEGAL |-> !CHK_WRITE_EN && CHK_VALID)
        else $error("refused access allowed to write");
    a_missing_trap: assert property (REQ_VALID && is_csr && !CSR_EXISTS |=> s_trap and CHK_CAUSE[0])
        else $error("missing register not trapped");
    a_debug_window: assert property (REQ_VALID && is_csr && dec_dbg && !DEBUG_MODE |=> s_trap)
        else $error("debug window open outside debug mode");
    a_top_allowed: assert property (s_top_rw_access |=> CHK_VALID && !CHK_ILLEGAL)
        else $error("top level refused a permitted access");
    a_level_update: assert property (PRIV_WR_VALID && (PRIV_WR_LEVEL == csr_priv_pkg::LVL_TOP)
        |=> PRIV_LEVEL == csr_priv_pkg::LVL_TOP)
        else $error("level update lost");
    a_ro_bits_kept: assert property (CHK_WRITE_EN |->
        ((CHK_WDATA ^ $past(OLD_DATA)) & $past(RO_MASK)) == '0)
        else $error("read-only bits changed by write");
    a_other_priv: assert property (REQ_VALID && is_other && !is_env && !DEBUG_MODE && (priv < INSN[29:28])
        |=> ##[0:0] s_trap)
        else $error("privileged instruction not trapped");
    a_intercept_only_ok: assert property (CHK_INTERCEPT |-> !CHK_ILLEGAL && !CHK_WRITE_EN)
        else $error("intercept mixed with trap or write");
    a_top_present: assert property (mode_set == csr_priv_pkg::SET_TOP |-> PRIV_LEVEL == csr_priv_pkg::LVL_TOP
        or ##1 PRIV_LEVEL == csr_priv_pkg::LVL_TOP)
        else $error("lower level active with top-only set");

    // Each request gets exactly one answer, one cycle later, and idle cycles answer nothing
    a_answer_timing: assert property (REQ_VALID |=> CHK_VALID)
        else $error("check answer missing");
    a_no_stray_answer: assert property (!REQ_VALID |=> !CHK_VALID && !CHK_ILLEGAL && !CHK_WRITE_EN)
        else $error("answer without a request");
    // The reserved register form must trap as a missing register, not slip through as a plain access
    a_reserved_trap: assert property (REQ_VALID && is_rsvd |=> s_trap and CHK_CAUSE[0])
        else $error("reserved register form not trapped");
    // Reading a read-only register from a high enough level is never refused
    a_ro_read_ok: assert property (REQ_VALID && is_csr && !csr_wr && CSR_EXISTS
        && (INSN[31:30] == csr_priv_pkg::ACC_RO) && (priv >= INSN[29:28]) && lvl_impl(mode_set, dec_min)
        |=> CHK_VALID && !CHK_ILLEGAL)
        else $error("read of read-only register refused");
endmodule

/* tb/pipe_model.sv */
// Pipeline model that sends one register access at a time and keeps the answer
`timescale 1ns/1ps
module pipe_model (
    input wire logic clock, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic issue, // Bench asks for one access
    input wire logic [31:0] issue_insn, // Instruction to send
    input wire logic issue_exists, // Register present flag to send
    output logic req_valid, // Request to the checker
    output logic [31:0] insn, // Instruction word
    output logic csr_exists, // Register present
    input wire logic chk_valid, // Answer strobe
    input wire logic [8:0] chk_flags, // Illegal, intercept, write, standard, shadow, cause
    input wire logic [31:0] chk_wdata, // Merged write value
    output logic done, // Answer taken, one cycle
    output logic [8:0] flags, // Kept flags
    output logic [31:0] wdata // Kept write value
);
    // Idle lines show the inverse of their last value, so a stale word never passes for a live one
    always_ff @(posedge clock)
    begin
        req_valid <= rst_n && issue;
        done <= rst_n && chk_valid;
        insn <= !rst_n ? 32'h0000_0000 : issue ? issue_insn : ~insn;
        csr_exists <= issue ? issue_exists : ~csr_exists;
        if (chk_valid)
        begin
            flags <= chk_flags; // Answer stands one cycle, so it is taken then
            wdata <= chk_wdata;
        end
    end
endmodule

/* tb/test_csr_privilege_checker.sv */
// Self-checking bench for the register-access privilege checker
`timescale 1ns/1ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_csr_privilege_checker;
    int fail_count = 0, tests_run = 0;
    logic clock = 1'b0, rst_n = 1'b0, issue = 1'b0, issue_exists = 1'b1, debug_mode = 1'b0, pw_valid = 1'b0;
    logic [31:0] issue_insn = 32'h0, wr_data = 32'h0, old_data = 32'h0, ro_mask = 32'h0, w_data = 32'h0;
    logic [1:0] pw_level = 2'h0;
    logic [7:0] aw_addr = 8'h0, ar_addr = 8'h0;
    logic [3:0] w_strb = 4'h0;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    wire logic req_valid, csr_exists, chk_valid, irq, done, aw_ready, w_ready, bvalid, ar_ready, rvalid;
    wire logic [8:0] f, flags;
    wire logic [1:0] lvl, bresp, rresp;
    wire logic [31:0] insn, chk_wd, cap_wd, rdata;
    csr_privilege_checker #(.XLEN(32)) csr_privilege_checker_i (
        .CLOCK(clock), .RST_N(rst_n), .REQ_VALID(req_valid), .INSN(insn), .CSR_EXISTS(csr_exists),
        .WR_DATA(wr_data), .OLD_DATA(old_data), .RO_MASK(ro_mask), .DEBUG_MODE(debug_mode),
        .PRIV_WR_VALID(pw_valid), .PRIV_WR_LEVEL(pw_level), .PRIV_LEVEL(lvl), .CHK_VALID(chk_valid),
        .CHK_ILLEGAL(f[8]), .CHK_INTERCEPT(f[7]), .CHK_WRITE_EN(f[6]), .CHK_STANDARD(f[5]),
        .CHK_SHADOW(f[4]), .CHK_CAUSE(f[3:0]), .CHK_WDATA(chk_wd), .IRQ(irq),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
        .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(r_ready));
    pipe_model pipe_model_i (.clock(clock), .rst_n(rst_n), .issue(issue), .issue_insn(issue_insn),
        .issue_exists(issue_exists), .req_valid(req_valid), .insn(insn), .csr_exists(csr_exists),
        .chk_valid(chk_valid), .chk_flags(f), .chk_wdata(chk_wd), .done(done), .flags(flags), .wdata(cap_wd));

    // Write access: csrrw with rs1=1; read access: csrrs with rs1=0
    function automatic logic [31:0] mk(input logic [11:0] c, input logic wr);
        return {c, wr ? 8'h09 : 8'h02, 5'h01, csr_priv_pkg::OPC_PRIV};
    endfunction

    // Both write channels offered at once, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        @(posedge clock);
        aw_addr <= a;
        w_data <= d;
        w_strb <= 4'hf;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (aw_valid && aw_ready)
                aw_valid <= 1'b0;
            if (w_valid && w_ready)
                w_valid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 50);
        b_ready <= 1'b0;
        `CHECK(bvalid, 1'b1)
        `CHECK(bresp, r)
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        @(posedge clock);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (ar_valid && ar_ready)
                ar_valid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 50);
        r_ready <= 1'b0;
        `CHECK(rvalid, 1'b1)
        `CHECK(rresp, r)
        `CHECK(rdata, d)
    endtask

    // One access through the pipeline model; only the bits in m are judged
    task automatic chk(input logic [31:0] ins, input logic ex, input logic [8:0] e, input logic [8:0] m);
        int n = 0;
        @(posedge clock);
        issue_insn <= ins;
        issue_exists <= ex;
        issue <= 1'b1;
        @(posedge clock);
        issue <= 1'b0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (done !== 1'b1 && n < 20);
        `CHECK(done, 1'b1)
        `CHECK(flags & m, e & m)
    endtask

    task automatic set_lvl(input logic [1:0] l, input logic [1:0] e);
        @(posedge clock);
        pw_level <= l;
        pw_valid <= 1'b1;
        @(posedge clock);
        pw_valid <= 1'b0;
        @(posedge clock);
        `CHECK(lvl, e)
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_reset;
        `CHECK(lvl, csr_priv_pkg::LVL_TOP)
        `CHECK(irq, 1'b0)
        axi_rd(csr_priv_pkg::OFS_CTRL, {24'h0, csr_priv_pkg::CTRL_RST}, csr_priv_pkg::RESP_OKAY);
        axi_rd(csr_priv_pkg::OFS_STATUS, 32'h3, csr_priv_pkg::RESP_OKAY);
        axi_rd(csr_priv_pkg::OFS_MASK, 32'h0, csr_priv_pkg::RESP_OKAY);
        axi_rd(8'h40, 32'h0, csr_priv_pkg::RESP_SLVERR);
        axi_wr(8'h40, 32'hff, csr_priv_pkg::RESP_SLVERR);
    endtask

    // Every current level against every lowest-allowed level, top level first
    task automatic t_priv;
        for (int c = 3; c >= 0; c--)
        begin
            set_lvl(c[1:0], c[1:0]);
            for (int r = 0; r < 4; r++)
                chk(mk({2'b00, r[1:0], 8'h00}, 1'b1), 1'b1, {c < r, 1'b0, c >= r, 3'b100, c < r, 2'b00}, 9'h1ff);
        end
    endtask

    // Sticky event, masked in, then cleared by writing a one
    task automatic t_irq;
        axi_rd(csr_priv_pkg::OFS_EVENT, 32'h2, csr_priv_pkg::RESP_OKAY);
        `CHECK(irq, 1'b0)
        axi_wr(csr_priv_pkg::OFS_MASK, 32'h2, csr_priv_pkg::RESP_OKAY);
        @(posedge clock);
        `CHECK(irq, 1'b1)
        axi_wr(csr_priv_pkg::OFS_EVENT, 32'h2, csr_priv_pkg::RESP_OKAY);
        @(posedge clock);
        `CHECK(irq, 1'b0)
        axi_rd(csr_priv_pkg::OFS_EVENT, 32'h0, csr_priv_pkg::RESP_OKAY);
    endtask

    task automatic t_misc;
        axi_wr(csr_priv_pkg::OFS_CTRL, 32'h13, csr_priv_pkg::RESP_OKAY);
        chk(mk(12'h000, 1'b1), 1'b1, 9'h0a0, 9'h1ff);
        axi_wr(csr_priv_pkg::OFS_CTRL, 32'h03, csr_priv_pkg::RESP_OKAY);
        chk(32'h00000073, 1'b1, 9'h000, 9'h1bf);
        chk({12'h105, 13'h0000, csr_priv_pkg::OPC_PRIV}, 1'b1, 9'h104, 9'h1ff);
        chk({12'h300, 8'h0c, 5'h01, csr_priv_pkg::OPC_PRIV}, 1'b1, 9'h101, 9'h101);
        axi_wr(csr_priv_pkg::OFS_CTRL, 32'h00, csr_priv_pkg::RESP_OKAY);
        @(posedge clock);
        `CHECK(lvl, csr_priv_pkg::LVL_TOP)
        set_lvl(2'h0, 2'h3);
        axi_wr(csr_priv_pkg::OFS_CTRL, 32'h01, csr_priv_pkg::RESP_OKAY);
        set_lvl(2'h2, 2'h3);
        axi_wr(csr_priv_pkg::OFS_CTRL, 32'h03, csr_priv_pkg::RESP_OKAY);
    endtask

    // Top-level accesses: read-only, class, shadow, missing register and debug window
    task automatic t_top;
        wr_data <= 32'hffffffff;
        old_data <= 32'h12345678;
        ro_mask <= 32'h0000ffff;
        chk(mk(12'hc00, 1'b1), 1'b1, 9'h128, 9'h1ff);
        chk(mk(12'hc00, 1'b0), 1'b1, 9'h020, 9'h1bf);
        chk(mk(12'hcc0, 1'b0), 1'b1, 9'h000, 9'h1bf);
        chk(mk(12'h900, 1'b1), 1'b1, 9'h070, 9'h1ff);
        `CHECK(cap_wd, 32'hffff5678)
        chk(mk(12'h300, 1'b1), 1'b0, 9'h121, 9'h1ff);
        chk(mk(12'h7a0, 1'b1), 1'b1, 9'h102, 9'h1df);
        chk(mk(12'h7b0, 1'b1), 1'b1, 9'h103, 9'h1df);
        axi_wr(csr_priv_pkg::OFS_CTRL, 32'h07, csr_priv_pkg::RESP_OKAY);
        debug_mode <= 1'b1;
        chk(mk(12'h7b0, 1'b1), 1'b1, 9'h040, 9'h1df);
        debug_mode <= 1'b0;
    endtask

    // Core clock, 25 ns period
    initial
    begin
        forever #12.5 clock = ~clock;
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        print_verdict;
    end

    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset;
        t_priv;
        t_irq;
        t_misc;
        t_top;
        print_verdict;
    end
endmodule
